// File: tcsm_pkg.sv
package tcsm_pkg;

  // ------------------------------------------------------------
  // Status register indices
  // ------------------------------------------------------------
  localparam logic [4:0] STAT_CHANNEL_BER_LOW       = 5'h0D;
  localparam logic [4:0] STAT_CHANNEL_BER_HIGH      = 5'h0E;
  localparam logic [4:0] STAT_CORRECTED_ERRORS_LOW  = 5'h0F;
  localparam logic [4:0] STAT_CORRECTED_ERRORS_HIGH = 5'h10;
  localparam logic [4:0] STAT_WINDOW_ERRORS_BYTE0   = 5'h11;
  localparam logic [4:0] STAT_WINDOW_ERRORS_BYTE1   = 5'h12;
  localparam logic [4:0] STAT_WINDOW_ERRORS_BYTE2   = 5'h13;
  localparam logic [4:0] STAT_TOTAL_ERRORS_BYTE0    = 5'h14;
  localparam logic [4:0] STAT_TOTAL_ERRORS_BYTE1    = 5'h15;
  localparam logic [4:0] STAT_TOTAL_ERRORS_BYTE2    = 5'h16;
  localparam logic [4:0] STAT_TOTAL_ERRORS_BYTE3    = 5'h17;
  localparam logic [4:0] STAT_TOTAL_BITS_BYTE0      = 5'h18;
  localparam logic [4:0] STAT_TOTAL_BITS_BYTE1      = 5'h19;
  localparam logic [4:0] STAT_TOTAL_BITS_BYTE2      = 5'h1A;
  localparam logic [4:0] STAT_TOTAL_BITS_BYTE3      = 5'h1B;

  // ------------------------------------------------------------
  // Field positions and measurement constants
  // ------------------------------------------------------------
  localparam int          CRC_FAIL_BIT       = 4;
  localparam int          CORR_HIGH_WIDTH    = 4;
  localparam logic [10:0] CHAN_SPAN_BITS     = 11'h400;
  localparam logic [3:0]  CHAN_REFRESH_LAST  = 4'hF;
  localparam logic [19:0] WINDOW_LAST_BIT    = 20'hF423F;
  localparam logic [10:0] PRBS_SEED          = 11'h7FF;
  localparam int          PRBS_TAP_HI        = 10;
  localparam int          PRBS_TAP_LO        = 8;
  localparam logic [5:0]  UW_MIN_MATCH       = 6'h1C;
  localparam int          UW_WIDTH           = 32;
  localparam logic [31:0] UW_PATTERN_DEFAULT = 32'h1ACFFC1D;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic encoder_busy;
    logic decoder_busy;
    logic encoder_in_frames;
    logic encoder_out_nonempty;
    logic decoder_in_frames;
    logic decoder_out_nonempty;
    logic uw_insert;
    logic frame_lock;
  } tcsm_activity_type;

  typedef struct packed {
    logic [15:0] channel_ber;
    logic [11:0] corrected;
    logic        crc_fail;
    logic [23:0] window_errors;
    logic [31:0] total_errors;
    logic [31:0] total_bits;
  } tcsm_snapshot_type;

  typedef struct packed {
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
  } tcsm_test_pins_type;

endpackage

// File: tcsm_status_monitor.sv
// Functional notes
// - Count unique word bit errors over 1024 bits
// - Refresh channel error result every 16 frames
// - Compare decoded bits against local PRBS-11
// - Window error count over 1,000,000 decoded bits
// - Window count latched at the end of every window, next starts immediately
// - Cumulative 32-bit decoded error counter
// - Cumulative 32-bit decoded bit counter
// - First channel byte read snapshots all values
// - Status registers are read-only
// - Encoder idle high when encoder empty
// - Decoder idle high when decoder empty
// - Unique word detect at 28 of 32
// - Tester error pulse per bad decoded bit
// - Unique word transmit enable indicator
// - Frame lock high while preambles on time
// - Encoder input flag: full frame ready
// - Encoder output flag: buffer non-empty
// - Decoder input flag: full frame ready
// - Decoder output flag: buffer non-empty
// - Special test points driven only when enabled
// - Strip unique word before correction when enabled
// - Reference is 2047-bit 11-stage sequence
`timescale 1ns/100ps
`default_nettype none

module tcsm_status_monitor
  import tcsm_pkg::*;
#(
  parameter logic [31:0] UW_PATTERN = UW_PATTERN_DEFAULT
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  // Received coded hard bits
  input  wire logic              rx_bit,
  input  wire logic              rx_bit_valid,
  input  wire logic              rx_uw_sync_enable,
  input  wire logic              rx_uw_bit_valid,
  input  wire logic              rx_frame_start,
  // Per-frame decoder results
  input  wire logic [11:0]       frame_corrected,
  input  wire logic              frame_crc_fail,
  input  wire logic              frame_result_valid,
  // Decoder output stream
  input  wire logic              dec_bit,
  input  wire logic              dec_bit_valid,
  // Datapath activity
  input  wire tcsm_activity_type activity,
  input  wire logic              test_point_enable,
  // Status register read port
  input  wire logic [4:0]        stat_addr,
  input  wire logic              stat_read,
  input  wire logic              stat_write,
  input  wire logic [7:0]        stat_wdata,
  output logic [7:0]             stat_rdata,
  // Data to the correction stage
  output logic                   corr_bit,
  output logic                   corr_bit_valid,
  // Test points
  output logic                   encoder_idle,
  output logic                   decoder_idle,
  output logic                   uw_detect_indicator,
  output logic                   tester_error_pulse,
  output logic                   uw_transmit_indicator,
  output tcsm_test_pins_type     special_pins
);

  // ------------------------------------------------------------
  // Unique word detection and stripping
  // ------------------------------------------------------------
  logic [31:0] uw_shift_reg;
  logic [5:0]  uw_match_count;
  logic        uw_detect_reg;

  always_comb
  begin
    uw_match_count = 6'h00;
    for (int i = 0; i < UW_WIDTH; i++)
    begin
      uw_match_count = uw_match_count + {5'h00, ~(uw_shift_reg[i] ^ UW_PATTERN[i])};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      uw_shift_reg  <= 32'h00000000;
      uw_detect_reg <= 1'b0;
    end
    else
    begin
      if (rx_bit_valid)
      begin
        uw_shift_reg <= {uw_shift_reg[30:0], rx_bit};
      end
      uw_detect_reg <= (uw_match_count >= UW_MIN_MATCH);
    end
  end

  // Unique word bits reach the correction stage only while rx_uw_sync_enable is low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      corr_bit       <= 1'b0;
      corr_bit_valid <= 1'b0;
    end
    else
    begin
      corr_bit       <= rx_bit;
      corr_bit_valid <= rx_bit_valid && !(rx_uw_sync_enable && rx_uw_bit_valid);
    end
  end

  // ------------------------------------------------------------
  // Channel bit error measurement
  // ------------------------------------------------------------
  logic [4:0]  uw_bit_index_reg;
  logic [10:0] chan_bits_reg;
  logic [15:0] chan_errs_reg;
  logic [15:0] channel_ber_reg;
  logic        chan_done_reg;
  logic [3:0]  frame_count_reg;
  logic        uw_ref_bit;

  assign uw_ref_bit = UW_PATTERN[~uw_bit_index_reg];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      uw_bit_index_reg <= 5'h00;
      chan_bits_reg    <= 11'h000;
      chan_errs_reg    <= 16'h0000;
      chan_done_reg    <= 1'b0;
    end
    else if (rx_bit_valid && rx_uw_bit_valid && !chan_done_reg)
    begin
      uw_bit_index_reg <= uw_bit_index_reg + 5'h01;
      chan_errs_reg    <= chan_errs_reg + {15'h0000, rx_bit ^ uw_ref_bit};
      chan_bits_reg    <= chan_bits_reg + 11'h001;
      if (chan_bits_reg + 11'h001 == CHAN_SPAN_BITS)
      begin
        chan_done_reg <= 1'b1;
      end
    end
    else if (rx_frame_start && frame_count_reg == CHAN_REFRESH_LAST)
    begin
      uw_bit_index_reg <= 5'h00;
      chan_bits_reg    <= 11'h000;
      chan_errs_reg    <= 16'h0000;
      chan_done_reg    <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frame_count_reg <= 4'h0;
      channel_ber_reg <= 16'h0000;
    end
    else if (rx_frame_start)
    begin
      frame_count_reg <= frame_count_reg + 4'h1;
      if (frame_count_reg == CHAN_REFRESH_LAST)
      begin
        channel_ber_reg <= chan_errs_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Per-frame correction results
  // ------------------------------------------------------------
  logic [11:0] corrected_reg;
  logic        crc_fail_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      corrected_reg <= 12'h000;
      crc_fail_reg  <= 1'b0;
    end
    else if (frame_result_valid)
    begin
      corrected_reg <= frame_corrected;
      crc_fail_reg  <= frame_crc_fail;
    end
  end

  // ------------------------------------------------------------
  // Decoded bit error tester
  // ------------------------------------------------------------
  logic [10:0] prbs_reg;
  logic        prbs_ref;
  logic        dec_error;
  logic        tester_error_reg;
  logic [19:0] window_bits_reg;
  logic [23:0] window_count_reg;
  logic [23:0] window_errors_reg;
  logic [31:0] total_errors_reg;
  logic [31:0] total_bits_reg;

  // x^11 + x^9 + 1, period 2047
  assign prbs_ref  = prbs_reg[PRBS_TAP_HI] ^ prbs_reg[PRBS_TAP_LO];
  assign dec_error = dec_bit_valid && (dec_bit != prbs_ref);

  // Self-synchronising: the reference loads decoded bits so it locks to the stream
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prbs_reg         <= PRBS_SEED;
      tester_error_reg <= 1'b0;
    end
    else
    begin
      if (dec_bit_valid)
      begin
        prbs_reg <= {prbs_reg[9:0], dec_bit};
      end
      tester_error_reg <= dec_error;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      window_bits_reg   <= 20'h00000;
      window_count_reg  <= 24'h000000;
      window_errors_reg <= 24'h000000;
    end
    else if (dec_bit_valid)
    begin
      if (window_bits_reg == WINDOW_LAST_BIT)
      begin
        window_errors_reg <= window_count_reg + {23'h000000, dec_error};
        window_count_reg  <= 24'h000000;
        window_bits_reg   <= 20'h00000;
      end
      else
      begin
        window_count_reg <= window_count_reg + {23'h000000, dec_error};
        window_bits_reg  <= window_bits_reg + 20'h00001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      total_errors_reg <= 32'h00000000;
      total_bits_reg   <= 32'h00000000;
    end
    else if (dec_bit_valid)
    begin
      total_errors_reg <= total_errors_reg + {31'h00000000, dec_error};
      total_bits_reg   <= total_bits_reg + 32'h00000001;
    end
  end

  // ------------------------------------------------------------
  // Snapshot and read decode
  // ------------------------------------------------------------
  tcsm_snapshot_type snap_reg;
  tcsm_snapshot_type live;

  assign live = '{channel_ber:   channel_ber_reg,
                  corrected:     corrected_reg,
                  crc_fail:      crc_fail_reg,
                  window_errors: window_errors_reg,
                  total_errors:  total_errors_reg,
                  total_bits:    total_bits_reg};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      snap_reg <= '0;
    end
    else if (stat_read && stat_addr == STAT_CHANNEL_BER_LOW)
    begin
      snap_reg <= live;
    end
  end

  // Writes are accepted on the port but change nothing
  logic [7:0] read_next;

  always_comb
  begin
    read_next = 8'h00;
    unique case (stat_addr)
      STAT_CHANNEL_BER_LOW:       read_next = live.channel_ber[7:0];
      STAT_CHANNEL_BER_HIGH:      read_next = snap_reg.channel_ber[15:8];
      STAT_CORRECTED_ERRORS_LOW:  read_next = snap_reg.corrected[7:0];
      STAT_CORRECTED_ERRORS_HIGH:
      begin
        read_next = {3'h0, snap_reg.crc_fail, snap_reg.corrected[11:8]};
      end
      STAT_WINDOW_ERRORS_BYTE0:   read_next = snap_reg.window_errors[7:0];
      STAT_WINDOW_ERRORS_BYTE1:   read_next = snap_reg.window_errors[15:8];
      STAT_WINDOW_ERRORS_BYTE2:   read_next = snap_reg.window_errors[23:16];
      STAT_TOTAL_ERRORS_BYTE0:    read_next = snap_reg.total_errors[7:0];
      STAT_TOTAL_ERRORS_BYTE1:    read_next = snap_reg.total_errors[15:8];
      STAT_TOTAL_ERRORS_BYTE2:    read_next = snap_reg.total_errors[23:16];
      STAT_TOTAL_ERRORS_BYTE3:    read_next = snap_reg.total_errors[31:24];
      STAT_TOTAL_BITS_BYTE0:      read_next = snap_reg.total_bits[7:0];
      STAT_TOTAL_BITS_BYTE1:      read_next = snap_reg.total_bits[15:8];
      STAT_TOTAL_BITS_BYTE2:      read_next = snap_reg.total_bits[23:16];
      STAT_TOTAL_BITS_BYTE3:      read_next = snap_reg.total_bits[31:24];
      default:                    read_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stat_rdata <= 8'h00;
    end
    else if (stat_read && !stat_write)
    begin
      stat_rdata <= read_next;
    end
  end

  // ------------------------------------------------------------
  // Test points
  // ------------------------------------------------------------
  logic [5:0] pins_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      encoder_idle          <= 1'b0;
      decoder_idle          <= 1'b0;
      uw_transmit_indicator <= 1'b0;
      pins_reg              <= 6'h00;
    end
    else
    begin
      encoder_idle          <= !activity.encoder_busy;
      decoder_idle          <= !activity.decoder_busy;
      uw_transmit_indicator <= activity.uw_insert;
      pins_reg[0]           <= activity.frame_lock;
      pins_reg[1]           <= activity.encoder_in_frames;
      pins_reg[2]           <= activity.encoder_out_nonempty;
      pins_reg[3]           <= activity.decoder_in_frames;
      pins_reg[4]           <= activity.decoder_out_nonempty;
      pins_reg[5]           <= 1'b0;
    end
  end

  assign uw_detect_indicator   = uw_detect_reg;
  assign tester_error_pulse    = tester_error_reg;
  assign special_pins.pin_out  = pins_reg;
  assign special_pins.pin_oe   = {1'b0, {5{test_point_enable}}};

endmodule

`default_nettype wire

// File: tcsm_sva_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module tcsm_sva_monitor
  import tcsm_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               rx_bit,
  input wire logic               rx_bit_valid,
  input wire logic               rx_uw_sync_enable,
  input wire logic               rx_uw_bit_valid,
  input wire logic               dec_bit_valid,
  input wire tcsm_activity_type  activity,
  input wire logic               test_point_enable,
  input wire logic               stat_read,
  input wire logic               stat_write,
  input wire logic [4:0]         stat_addr,
  input wire logic [7:0]         stat_rdata,
  input wire logic               corr_bit,
  input wire logic               corr_bit_valid,
  input wire logic               encoder_idle,
  input wire logic               decoder_idle,
  input wire logic               tester_error_pulse,
  input wire logic               uw_detect_indicator,
  input wire logic               uw_transmit_indicator,
  input wire tcsm_test_pins_type special_pins
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Indicator and register checks
  // ------------------------------------------------------------
  a_encoder_idle_busy: assert property (activity.encoder_busy |=> !encoder_idle)
    else $error("encoder idle while busy");
  a_decoder_idle_free: assert property ($fell(activity.decoder_busy) |=> decoder_idle)
    else $error("decoder idle missing");
  a_tester_pulse_cause: assert property (tester_error_pulse |-> $past(dec_bit_valid))
    else $error("tester pulse without decoded bit");
  a_pins_float: assert property (special_pins.pin_oe == {1'b0, {5{test_point_enable}}})
    else $error("test pin enable wrong");
  a_lock_follow: assert property (activity.frame_lock && test_point_enable |=> special_pins.pin_out[0])
    else $error("frame lock pin low");
  a_buffer_flags: assert property (!$past(rst) |-> special_pins.pin_out[4:1] ==
    {$past(activity.decoder_out_nonempty), $past(activity.decoder_in_frames),
     $past(activity.encoder_out_nonempty), $past(activity.encoder_in_frames)})
    else $error("buffer flag pins wrong");
  a_uw_tx_mark: assert property ($rose(activity.uw_insert) |=> uw_transmit_indicator)
    else $error("unique word transmit indicator low");
  a_write_ignored: assert property (stat_write && !stat_read |=> $stable(stat_rdata))
    else $error("write changed read data");
  a_uw_stripped: assert property (rx_bit_valid && rx_uw_sync_enable && rx_uw_bit_valid |=> !corr_bit_valid)
    else $error("unique word bit reached correction");
  a_data_passed: assert property (rx_bit_valid && !rx_uw_bit_valid |=> corr_bit_valid && corr_bit == $past(rx_bit))
    else $error("data bit not forwarded");

  c_snapshot: cover property (stat_read && stat_addr == STAT_CHANNEL_BER_LOW);
  c_tester_error: cover property (tester_error_pulse);
  c_uw_found: cover property (uw_detect_indicator);
endmodule

bind tcsm_status_monitor tcsm_sva_monitor chk_u (
  .clk, .rst, .rx_bit, .rx_bit_valid, .rx_uw_sync_enable, .rx_uw_bit_valid, .dec_bit_valid,
  .activity, .test_point_enable, .stat_read, .stat_write, .stat_addr, .stat_rdata, .corr_bit,
  .corr_bit_valid, .encoder_idle, .decoder_idle, .tester_error_pulse, .uw_detect_indicator,
  .uw_transmit_indicator, .special_pins
);

`default_nettype wire

// File: tcsm_status_monitor_bench.sv
`timescale 1ns/100ps
`default_nettype none

module tcsm_status_monitor_bench
  import tcsm_pkg::*;
;
  logic               clk = 1'b0, rst = 1'b1, rx_bit = 1'b0, rx_bit_valid = 1'b0;
  logic               rx_uw_sync_enable = 1'b0, rx_uw_bit_valid = 1'b0, rx_frame_start = 1'b0;
  logic               dec_bit = 1'b0, dec_bit_valid = 1'b0, frame_crc_fail = 1'b0;
  logic               frame_result_valid = 1'b0, test_point_enable = 1'b0;
  logic               stat_read = 1'b0, stat_write = 1'b0;
  logic [11:0]        frame_corrected = 12'h000, last_corr;
  logic [4:0]         stat_addr = 5'h00;
  logic [7:0]         stat_wdata = 8'h00, stat_rdata;
  tcsm_activity_type  activity = '0;
  tcsm_test_pins_type special_pins;
  logic               corr_bit, corr_bit_valid, encoder_idle, decoder_idle, last_crc;
  logic               uw_detect_indicator, tester_error_pulse, uw_transmit_indicator;
  logic               e_pulse, e_uw, e_eidle, e_didle, e_uwtx, e_cv, e_cb;
  logic [5:0]         e_pins;
  logic [10:0]        hist, gen = 11'h7FF;
  logic [31:0]        seed = 32'h4DB1, rnd, rnd2, rx_sh, tot_err, tot_bits, s_err, s_bits;
  int                 errors = 0, n_tests = 0;
  int                 ch_acc = 0, ch_pub = 0;

  tcsm_status_monitor dut_u (
    .clk, .rst, .rx_bit, .rx_bit_valid, .rx_uw_sync_enable, .rx_uw_bit_valid, .rx_frame_start,
    .frame_corrected, .frame_crc_fail, .frame_result_valid, .dec_bit, .dec_bit_valid,
    .activity, .test_point_enable, .stat_addr, .stat_read, .stat_write, .stat_wdata,
    .stat_rdata, .corr_bit, .corr_bit_valid, .encoder_idle, .decoder_idle,
    .uw_detect_indicator, .tester_error_pulse, .uw_transmit_indicator, .special_pins
  );

  always #5 clk = ~clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    rnd = xs();
    activity <= rst ? '0 : tcsm_activity_type'(rnd[7:0]);
    test_point_enable <= !rst && rnd[9];
    // Detector acts on the history before this edge, forwarding on the bit sampled at it
    e_uw = !rst && $countones(~(rx_sh ^ UW_PATTERN_DEFAULT)) >= 28;
    e_cv = !rst && rx_bit_valid && !(rx_uw_sync_enable && rx_uw_bit_valid);
    e_cb = rx_bit;
    if (rst)
    begin
      hist = 11'h7FF;
      rx_sh = '0;
      tot_err = '0;
      tot_bits = '0;
      last_corr = '0;
      last_crc = 1'b0;
      e_pulse = 1'b0;
    end
    else
    begin
      e_pulse = dec_bit_valid && (dec_bit !== (hist[10] ^ hist[8]));
      if (dec_bit_valid)
      begin
        tot_err += e_pulse;
        tot_bits++;
        hist = {hist[9:0], dec_bit};
      end
      if (rx_bit_valid)
        rx_sh = {rx_sh[30:0], rx_bit};
      if (frame_result_valid)
      begin
        last_corr = frame_corrected;
        last_crc = frame_crc_fail;
      end
    end
    e_eidle = !rst && !activity.encoder_busy;
    e_didle = !rst && !activity.decoder_busy;
    e_uwtx = !rst && activity.uw_insert;
    e_pins = rst ? 6'h00 : {1'b0, activity.decoder_out_nonempty, activity.decoder_in_frames,
      activity.encoder_out_nonempty, activity.encoder_in_frames, activity.frame_lock};
  end

  always @(negedge clk)
  begin
    chk("tester_error_pulse", tester_error_pulse, e_pulse);
    chk("uw_detect_indicator", uw_detect_indicator, e_uw);
    chk("encoder_idle", encoder_idle, e_eidle);
    chk("decoder_idle", decoder_idle, e_didle);
    chk("uw_transmit_indicator", uw_transmit_indicator, e_uwtx);
    chk("corr_bit_valid", corr_bit_valid, e_cv);
    if (e_cv)
      chk("corr_bit", corr_bit, e_cb);
    chk("pin_oe", special_pins.pin_oe, {1'b0, {5{test_point_enable}}});
    if (test_point_enable)
      chk("pin_out", special_pins.pin_out, e_pins);
  end

  // ------------------------------------------------------------
  // Stimulus tasks
  // ------------------------------------------------------------
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    stat_addr <= a;
    stat_read <= 1'b1;
    @(posedge clk);
    stat_read <= 1'b0;
    @(negedge clk);
    chk(what, stat_rdata, exp);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    stat_addr <= a;
    stat_wdata <= d;
    stat_write <= 1'b1;
    @(posedge clk);
    stat_write <= 1'b0;
  endtask

  task automatic read_totals(input logic [31:0] e_err, input logic [31:0] e_bits);
    for (int k = 0; k < 4; k++)
    begin
      rd(STAT_TOTAL_ERRORS_BYTE0 + 5'(k), e_err[8*k +: 8], "total_errors");
      rd(STAT_TOTAL_BITS_BYTE0 + 5'(k), e_bits[8*k +: 8], "total_bits");
    end
    for (int k = 0; k < 3; k++)
      rd(STAT_WINDOW_ERRORS_BYTE0 + 5'(k), 32'h0, "window_errors");
  endtask

  task automatic dec_run(input int n);
    logic b;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      rnd2 = xs();
      b = gen[10] ^ gen[8];
      if (rnd2[1:0] != 2'h0)
        gen = {gen[9:0], b};
      dec_bit <= b ^ (rnd2[7:2] == 6'h00);
      dec_bit_valid <= rnd2[1:0] != 2'h0;
    end
    @(posedge clk);
    dec_bit_valid <= 1'b0;
  endtask

  initial
  begin
    repeat (50000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 13; a < 28; a++)
      rd(5'(a), 32'h0, "reset_status");
    rd(5'h02, 32'h0, "unmapped");
    dec_run(3000);
    rd(STAT_CHANNEL_BER_LOW, 32'h0, "channel_ber_low");
    read_totals(tot_err, tot_bits);
    s_err = tot_err;
    s_bits = tot_bits;
    dec_run(300);
    for (int a = 13; a < 28; a++)
      wr(5'(a), 8'(xs() >> 3));
    read_totals(s_err, s_bits);
    rd(STAT_CHANNEL_BER_LOW, 32'h0, "channel_ber_low");
    read_totals(tot_err, tot_bits);
    for (int f = 0; f < 18; f++)
    begin
      // Result of the fifteen frames before it is published as the sixteenth one starts
      if (f % 16 == 15)
      begin
        ch_pub = ch_acc;
        ch_acc = 0;
      end
      ch_acc += f % 6;
      rnd2 = xs();
      @(posedge clk);
      rx_bit_valid <= 1'b0;
      rx_frame_start <= 1'b1;
      frame_result_valid <= 1'b1;
      frame_corrected <= rnd2[11:0];
      frame_crc_fail <= rnd2[12];
      rx_uw_sync_enable <= f[0];
      for (int j = 0; j < 40; j++)
      begin
        @(posedge clk);
        rx_frame_start <= 1'b0;
        frame_result_valid <= 1'b0;
        rx_bit_valid <= 1'b1;
        rx_uw_bit_valid <= j < 32;
        rx_bit <= (j < 32) ? UW_PATTERN_DEFAULT[31 - j] ^ (j < f % 6) : rnd2[j - 20];
      end
    end
    @(posedge clk);
    rx_bit_valid <= 1'b0;
    rd(STAT_CHANNEL_BER_LOW, ch_pub[7:0], "channel_ber_low");
    rd(STAT_CHANNEL_BER_HIGH, ch_pub[15:8], "channel_ber_high");
    rd(STAT_CORRECTED_ERRORS_LOW, last_corr[7:0], "corrected_low");
    rd(STAT_CORRECTED_ERRORS_HIGH, {last_crc, last_corr[11:8]}, "corrected_high");
    tally_and_finish();
  end
endmodule

`default_nettype wire
